// ### include/lfs_pkg.sv
// Package with constants and types for the LNB fault status register bank.
package lfs_pkg;
	// Status byte one field positions.
	localparam int unsigned STAT_OFF_BIT = 0;
	localparam int unsigned STAT_OCP_BIT = 2;
	localparam int unsigned STAT_LOW_BIT = 4;
	localparam int unsigned STAT_TEMP_BIT = 6;
	localparam int unsigned STAT_UV_BIT = 7;
	// Status byte two carries no defined bit.
	localparam logic [7:0] STAT_SECONDARY_VALUE = 8'h00;
	// Control byte layout: six data bits, selector in the top two bits.
	localparam int unsigned CTRL_DATA_MSB = 5;
	localparam int unsigned CTRL_SEL_LSB = 6;
	localparam int unsigned CTRL_ON_BIT = 5;
	localparam logic [1:0] CTRL_SEL_MAIN = 2'h0;
	localparam logic [5:0] CTRL_MAIN_RESET = 6'h00;
	// Power-on values of the latched flags.
	localparam logic OFF_FLAG_RESET = 1'b1;
	localparam logic UV_FLAG_RESET = 1'b1;
	localparam logic IRQ_ACTIVE_RESET = 1'b1;
	// Serial slave address; value is arbitrary.
	localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h3a;
	// Overcurrent timer.
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned OCP_TIME_MS = 48;
	localparam int unsigned OCP_CYCLES = OCP_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned OCP_CNT_W = 23;
	// Number of event toggles crossing from the link into the system clock.
	localparam int unsigned EV_N = 5;
	localparam int unsigned EV_START = 0;
	localparam int unsigned EV_STOP = 1;
	localparam int unsigned EV_WRITE = 2;
	localparam int unsigned EV_RDADDR = 3;
	localparam int unsigned EV_NINTH = 4;
	// Link states.
	typedef enum logic [2:0] {
		LK_IDLE,
		LK_ADDR,
		LK_ACK_A,
		LK_WRITE,
		LK_ACK_W,
		LK_READ,
		LK_ACK_R
	} lfs_link_t;
endpackage

// ### logic/lfs_status_bank.sv
// Fault status flags and serial read/write slave of the LNB supply regulator.
//
// Contract
// - Overtemperature and undervoltage flags latch until read with fault gone.
// - Output-off flag latched until output commanded on.
// - Output-low, output-off and untimed overcurrent flags clear without a read.
// - Multi-byte read alternates status one, status two.
// - Each read transaction starts with status one.
// - All-zero status means normal operation.
// - Status one bits: 0,2,4,6,7; others unused.
// - Output-off set at power-on, never raises attention.
// - Write end clears output-off if output on.
// - Overcurrent over 48 ms switches off, sets flags.
// - Ninth read edge resamples, clears overcurrent in timer mode.
// - Without timer, overcurrent flag follows condition live.
// - Output-low sets below 85%, clears within 90%.
// - Overtemperature switches off; ninth edge resamples it.
// - Undervoltage switches off until enable written again.
// - Undervoltage resampled on ninth read clock edge.
// - Thermal shutdown after overcurrent sets both flags.
// - Status two has no functional bits.
// - Attention asserts on fault or power-on; read clears.
// - Control byte: six data bits, selector on top.
`timescale 1ns/1ps
`default_nettype none
module lfs_status_bank
	import lfs_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT,
	parameter int unsigned OCP_LIMIT = OCP_CYCLES
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic irq_n_o,
	output logic irq_n_oe,
	input wire logic ocp_detect,
	input wire logic ocp_timer_on,
	input wire logic temp_detect,
	input wire logic uv_detect,
	input wire logic out_below_low,
	input wire logic out_within_ok,
	output logic output_on_control
);

	////////////////////////////////////////////////////////////////////////////
	// Bus condition detectors, clocked by the data line itself.

	// Start and stop are the only events seen while the clock is high, so
	// they are caught on the data edges and passed on as toggles.
	logic start_tog;
	logic stop_tog;

	always_ff @(negedge sda_i or posedge rst)
	begin
		if (rst)
			start_tog <= 1'b0;
		else if (scl)
			start_tog <= ~start_tog;
	end

	always_ff @(posedge sda_i or posedge rst)
	begin
		if (rst)
			stop_tog <= 1'b0;
		else if (scl)
			stop_tog <= ~stop_tog;
	end

	////////////////////////////////////////////////////////////////////////////
	// Link side, clocked by the serial clock.

	lfs_link_t link_state;
	logic [2:0] bit_cnt;
	logic [7:0] shift;
	logic next_sel_secondary;
	logic start_seen;
	logic [7:0] ctrl_byte;
	logic wr_tog;
	logic rd_addr_tog;
	logic ninth_tog;
	logic [7:0] stat_meta;
	logic [7:0] stat_link;
	logic [7:0] stat_primary;
	logic addr_match;

	assign addr_match = (shift[7:1] == SLAVE_ADDR);

	// Status byte one brought over as levels; each bit settles on its own.
	always_ff @(posedge scl or posedge rst)
	begin
		if (rst)
		begin
			stat_meta <= 8'h00;
			stat_link <= 8'h00;
		end
		else
		begin
			stat_meta <= stat_primary;
			stat_link <= stat_meta;
		end
	end

	// The start toggle flips while the clock is high and is stable long
	// before the next rising edge, so it is compared directly there; a
	// two-stage synchroniser would swallow the first address bits.
	always_ff @(posedge scl or posedge rst)
	begin
		if (rst)
		begin
			link_state <= LK_IDLE;
			bit_cnt <= 3'h0;
			shift <= 8'h00;
			next_sel_secondary <= 1'b0;
			start_seen <= 1'b0;
			ctrl_byte <= 8'h00;
			wr_tog <= 1'b0;
			rd_addr_tog <= 1'b0;
			ninth_tog <= 1'b0;
		end
		else if (start_tog != start_seen)
		begin
			start_seen <= start_tog;
			shift <= {7'h00, sda_i};
			bit_cnt <= 3'h1;
			link_state <= LK_ADDR;
		end
		else
		begin
			case (link_state)
				LK_ADDR:
				begin
					shift <= {shift[6:0], sda_i};
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == 3'h7)
						link_state <= LK_ACK_A;
				end
				LK_ACK_A:
				begin
					bit_cnt <= 3'h0;
					if (!addr_match)
						link_state <= LK_IDLE;
					else if (shift[0])
					begin
						link_state <= LK_READ;
						shift <= stat_link;
						next_sel_secondary <= 1'b1;
						rd_addr_tog <= ~rd_addr_tog;
					end
					else
						link_state <= LK_WRITE;
				end
				LK_WRITE:
				begin
					shift <= {shift[6:0], sda_i};
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == 3'h7)
					begin
						ctrl_byte <= {shift[6:0], sda_i};
						wr_tog <= ~wr_tog;
						link_state <= LK_ACK_W;
					end
				end
				LK_ACK_W:
				begin
					bit_cnt <= 3'h0;
					link_state <= LK_WRITE;
				end
				LK_READ:
				begin
					shift <= {shift[6:0], 1'b0};
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == 3'h7)
						link_state <= LK_ACK_R;
				end
				LK_ACK_R:
				begin
					ninth_tog <= ~ninth_tog;
					bit_cnt <= 3'h0;
					if (sda_i)
						link_state <= LK_IDLE;
					else
					begin
						link_state <= LK_READ;
						if (next_sel_secondary)
							shift <= STAT_SECONDARY_VALUE;
						else
							shift <= stat_link;
						next_sel_secondary <= ~next_sel_secondary;
					end
				end
				default:
					link_state <= LK_IDLE;
			endcase
		end
	end

	// Data line is driven on the falling clock so it is stable at the rise.
	always_ff @(negedge scl or posedge rst)
	begin
		if (rst)
			sda_oe <= 1'b0;
		else
			sda_oe <= (link_state == LK_ACK_A && addr_match) || link_state == LK_ACK_W
				|| (link_state == LK_READ && !shift[7]);
	end

	// Open-drain lines only ever pull low.
	always_ff @(negedge scl or posedge rst)
	begin
		if (rst)
			sda_o <= 1'b0;
		else
			sda_o <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Event crossing into the system clock.

	logic [EV_N-1:0] ev_tog;
	logic [EV_N-1:0] ev_meta;
	logic [EV_N-1:0] ev_sync;
	logic [EV_N-1:0] ev_prev;
	logic [EV_N-1:0] ev;

	assign ev_tog = {ninth_tog, rd_addr_tog, wr_tog, stop_tog, start_tog};
	assign ev = ev_sync ^ ev_prev;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ev_meta <= '0;
			ev_sync <= '0;
			ev_prev <= '0;
		end
		else if (ce)
		begin
			ev_meta <= ev_tog;
			ev_sync <= ev_meta;
			ev_prev <= ev_sync;
		end
	end

	// Analog detector inputs arrive asynchronously.
	logic [5:0] det_meta;
	logic [5:0] det;
	logic ocp_det;
	logic timer_on;
	logic temp_det;
	logic uv_det;
	logic low_det;
	logic ok_det;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			det_meta <= 6'h00;
			det <= 6'h00;
		end
		else if (ce)
		begin
			det_meta <= {ocp_detect, ocp_timer_on, temp_detect, uv_detect, out_below_low,
				out_within_ok};
			det <= det_meta;
		end
	end

	assign {ocp_det, timer_on, temp_det, uv_det, low_det, ok_det} = det;

	////////////////////////////////////////////////////////////////////////////
	// Control write, applied at the end of the write sequence.

	logic pend_valid;
	logic [7:0] pend_byte;
	logic [7:0] apply_byte;
	logic seq_end;
	logic apply_main;
	logic apply_on;

	assign apply_byte = ev[EV_WRITE] ? ctrl_byte : pend_byte;
	assign seq_end = ev[EV_START] | ev[EV_STOP];
	assign apply_main = seq_end && (pend_valid || ev[EV_WRITE])
		&& apply_byte[7:CTRL_SEL_LSB] == CTRL_SEL_MAIN;
	// The output only comes on when no trip condition is still present.
	assign apply_on = apply_byte[CTRL_ON_BIT] && !temp_det && !uv_det;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pend_valid <= 1'b0;
			pend_byte <= 8'h00;
		end
		else if (ce)
		begin
			pend_byte <= apply_byte;
			pend_valid <= (pend_valid || ev[EV_WRITE]) && !seq_end;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Overcurrent timer.

	logic [OCP_CNT_W-1:0] ocp_cnt;
	logic ocp_trip;

	assign ocp_trip = timer_on && ocp_det && ocp_cnt == OCP_CNT_W'(OCP_LIMIT - 1);

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			ocp_cnt <= '0;
		else if (ce)
		begin
			if (!ocp_det || !timer_on || !output_on_control)
				ocp_cnt <= '0;
			else if (!ocp_trip)
				ocp_cnt <= ocp_cnt + OCP_CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fault flags.

	logic off_flag;
	logic overcurrent_flag;
	logic output_low_flag;
	logic overtemp_flag;
	logic input_undervolt_flag;
	logic trip;

	assign trip = ocp_trip || temp_det || uv_det;

	// Output enable and the output-off flag move together; a trip wins.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			output_on_control <= CTRL_MAIN_RESET[CTRL_ON_BIT];
			off_flag <= OFF_FLAG_RESET;
		end
		else if (ce)
		begin
			if (trip)
			begin
				output_on_control <= 1'b0;
				off_flag <= 1'b1;
			end
			else if (apply_main)
			begin
				output_on_control <= apply_on;
				off_flag <= !apply_on;
			end
		end
	end

	// Timer mode latches until the ninth read edge; without the timer the flag
	// simply tracks the condition.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			overcurrent_flag <= 1'b0;
		else if (ce)
		begin
			if (!timer_on)
				overcurrent_flag <= ocp_det;
			else if (ocp_trip)
				overcurrent_flag <= 1'b1;
			else if (ev[EV_NINTH])
				overcurrent_flag <= 1'b0;
		end
	end

	// Set wins over the resample clear when the condition is still there.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			overtemp_flag <= 1'b0;
			input_undervolt_flag <= UV_FLAG_RESET;
		end
		else if (ce)
		begin
			if (temp_det)
				overtemp_flag <= 1'b1;
			else if (ev[EV_NINTH])
				overtemp_flag <= 1'b0;
			if (uv_det)
				input_undervolt_flag <= 1'b1;
			else if (ev[EV_NINTH])
				input_undervolt_flag <= 1'b0;
		end
	end

	// Hysteresis between the low and in-range thresholds; cleared with no read.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			output_low_flag <= 1'b0;
		else if (ce)
		begin
			if (!output_on_control)
				output_low_flag <= 1'b0;
			else if (low_det)
				output_low_flag <= 1'b1;
			else if (ok_det)
				output_low_flag <= 1'b0;
		end
	end

	// Unused positions stay zero so an all-zero byte means healthy.
	always_comb
	begin
		stat_primary = 8'h00;
		stat_primary[STAT_OFF_BIT] = off_flag;
		stat_primary[STAT_OCP_BIT] = overcurrent_flag;
		stat_primary[STAT_LOW_BIT] = output_low_flag;
		stat_primary[STAT_TEMP_BIT] = overtemp_flag;
		stat_primary[STAT_UV_BIT] = input_undervolt_flag;
	end

	////////////////////////////////////////////////////////////////////////////
	// Attention request.

	logic [2:0] fault_prev;
	logic [2:0] fault_now;
	logic fault_new;

	// Only the three fault flags count; output-off and output-low never do.
	assign fault_now = {overcurrent_flag, overtemp_flag, input_undervolt_flag};
	assign fault_new = |(fault_now & ~fault_prev);

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			fault_prev <= 3'h0;
			irq_n_oe <= IRQ_ACTIVE_RESET;
		end
		else if (ce)
		begin
			fault_prev <= fault_now;
			if (fault_new)
				irq_n_oe <= 1'b1;
			else if (ev[EV_RDADDR])
				irq_n_oe <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			irq_n_o <= 1'b0;
		else
			irq_n_o <= 1'b0;
	end

endmodule
`default_nettype wire

// ### testbench/lfs_status_bank_properties.sv
// Concurrent checks on the ports of the fault status bank.
`timescale 1ns/1ps
`default_nettype none
module lfs_status_bank_properties
#(
	parameter int unsigned OCP_LIMIT = 20
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic scl,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic irq_n_o,
	input wire logic irq_n_oe,
	input wire logic ocp_detect,
	input wire logic ocp_timer_on,
	input wire logic temp_detect,
	input wire logic uv_detect,
	input wire logic out_below_low,
	input wire logic out_within_ok,
	input wire logic output_on_control
);
	int unsigned fault_age = 99;
	int unsigned stop_age = 99;
	int unsigned scl_age = 99;
	int unsigned ocp_run = 0;
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	function automatic int unsigned sat(int unsigned v);
		return v < 99 ? v + 1 : v;
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// Ages are counted in system cycles, so the serial lines are only sampled here.
	always_ff @(posedge clk_sys)
	begin
		scl_q <= scl;
		sda_q <= sda_i;
		fault_age <= (ocp_detect || temp_detect || uv_detect) ? 0 : sat(fault_age);
		stop_age <= (scl && scl_q && sda_i && !sda_q) ? 0 : sat(stop_age);
		scl_age <= (scl != scl_q) ? 0 : sat(scl_age);
		ocp_run <= !(ocp_detect && ocp_timer_on) ? 0 : (ocp_run < OCP_LIMIT + 20 ? ocp_run + 1 : ocp_run);
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_temp_trip_off: assert property (temp_detect [*8] |-> !output_on_control)
		else $error("output on under overtemperature");
	chk_uv_trip_off: assert property (uv_detect [*8] |-> !output_on_control)
		else $error("output on under undervoltage");
	chk_ocp_timeout: assert property (ocp_run == OCP_LIMIT + 12 |-> !output_on_control)
		else $error("overcurrent timeout did not switch off");
	chk_enable_at_stop: assert property ($rose(output_on_control) |-> stop_age < 16)
		else $error("output enabled away from a stop");
	chk_irq_cause: assert property ($rose(irq_n_oe) |-> fault_age < 8)
		else $error("attention raised without a fault");
	chk_irq_release: assert property ($fell(irq_n_oe) |-> scl_age < 20)
		else $error("attention released without bus traffic");
	chk_irq_power_on: assert property ($fell(rst) |-> irq_n_oe)
		else $error("attention not active after reset");
	chk_data_stable: assert property (scl && $past(scl) |-> $stable(sda_oe))
		else $error("data line changed while clock high");
	chk_drain_low: assert property (!sda_o && !irq_n_o)
		else $error("open drain driven high");
endmodule
bind lfs_status_bank lfs_status_bank_properties #(.OCP_LIMIT(OCP_LIMIT)) chk (
	.clk_sys(clk_sys), .rst(rst), .ce(ce), .scl(scl), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe(sda_oe), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .ocp_detect(ocp_detect),
	.ocp_timer_on(ocp_timer_on), .temp_detect(temp_detect), .uv_detect(uv_detect),
	.out_below_low(out_below_low), .out_within_ok(out_within_ok),
	.output_on_control(output_on_control));
`default_nettype wire

// ### testbench/lfs_bus_master.sv
// Serial bus master model that writes control bytes and polls the status bytes.
`timescale 1ns/1ps
`default_nettype none
module lfs_bus_master
	import lfs_pkg::*;
#(
	parameter logic [6:0] ADDR = SLAVE_ADDR_DEFAULT
)
(
	output logic scl,
	output logic sda_pull,
	input wire logic sda,
	output logic [7:0] rd_byte,
	output logic rd_tgl
);
	// The clock stands high between frames; a released data line rests at its pull-up.
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
		rd_byte = 8'h00;
		rd_tgl = 1'b0;
	end
	task automatic bit_io(input logic b, output logic r);
		sda_pull = !b;
		#16 scl = 1'b1;
		#16 r = sda;
		#16 scl = 1'b0;
		#16;
	endtask
	task automatic start();
		sda_pull = 1'b0;
		#16 scl = 1'b1;
		#16 sda_pull = 1'b1;
		#16 scl = 1'b0;
		#16;
	endtask
	task automatic stop();
		sda_pull = 1'b1;
		#16 scl = 1'b1;
		#16 sda_pull = 1'b0;
		#16;
	endtask
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(last, a);
	endtask
	// Polling read: acks every byte but the last, as a rereading host does.
	task automatic rd(input int n);
		logic [7:0] q;
		start();
		xfer({ADDR, 1'b1}, 1'b1, q);
		for (int k = 0; k < n; k++)
		begin
			xfer(8'hff, k == n - 1, q);
			rd_byte = q;
			rd_tgl = !rd_tgl;
		end
		stop();
	endtask
	task automatic wr(input logic [7:0] b);
		logic [7:0] q;
		start();
		xfer({ADDR, 1'b0}, 1'b1, q);
		xfer(b, 1'b1, q);
		stop();
	endtask
endmodule
`default_nettype wire

// ### testbench/test_lfs_status_bank.sv
// Self-checking testbench for the fault status register bank.
`timescale 1ns/1ps
`default_nettype none
module test_lfs_status_bank;
	logic clk_sys, rst, ocp_detect, ocp_timer_on, temp_detect, uv_detect;
	logic out_below_low, out_within_ok, sda_o, sda_oe, irq_n_o, irq_n_oe, output_on_control;
	logic scl, m_pull, rd_tgl, sda_line, ce;
	logic [7:0] rd_byte, f, en;
	logic [7:0] exp_q[$];
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	int seed = 32'h700936ef;
	assign sda_line = !(m_pull || sda_oe);
	lfs_status_bank #(.OCP_LIMIT(20)) uut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .scl(scl),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .irq_n_o(irq_n_o),
		.irq_n_oe(irq_n_oe), .ocp_detect(ocp_detect), .ocp_timer_on(ocp_timer_on),
		.temp_detect(temp_detect), .uv_detect(uv_detect), .out_below_low(out_below_low),
		.out_within_ok(out_within_ok), .output_on_control(output_on_control));
	lfs_bus_master host (.scl(scl), .sda_pull(m_pull), .sda(sda_line), .rd_byte(rd_byte),
		.rd_tgl(rd_tgl));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Expected bytes are packed lowest byte first, in the order they come off the bus.
	task automatic rd(input int n, input logic [31:0] e);
		for (int i = 0; i < n; i++)
			exp_q.push_back(e[8 * i +: 8]);
		host.rd(n);
		wt(4);
	endtask
	task automatic wr(input logic [7:0] b);
		host.wr(b);
		wt(20);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			conclude();
		end
	end
	always @(rd_tgl)
		if ($time > 0)
			check(rd_byte, exp_q.pop_front());
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		{ocp_detect, ocp_timer_on, temp_detect, uv_detect, out_below_low} = 5'h00;
		out_within_ok = 1'b1;
		wt(10);
		rst = 1'b0;
		wt(5);
		check(8'(irq_n_oe), 8'h01);
		rd(4, 32'h00010081);
		check(8'(irq_n_oe), 8'h00);
		rd(1, 32'h01);
		en = 8'h20 | 8'($random(seed) & 31);
		wr(en);
		check(8'(output_on_control), 8'h01);
		wr(8'h80);
		check(8'(output_on_control), 8'h01);
		rd(1, 32'h00);
		// With the clock enable low the flags hold, so the low output stays unseen.
		ce = 1'b0;
		{out_below_low, out_within_ok} = 2'b10;
		wt(20);
		rd(1, 32'h00);
		ce = 1'b1;
		wt(20);
		rd(1, 32'h10);
		{out_below_low, out_within_ok} = 2'b01;
		wt(20);
		rd(1, 32'h00);
		check(8'(irq_n_oe), 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			f = i ? 8'h81 : 8'h41;
			{uv_detect, temp_detect} = 2'(i + 1);
			wt(20);
			check(8'(output_on_control), 8'h00);
			check(8'(irq_n_oe), 8'h01);
			wr(8'h20 | 8'($random(seed) & 31));
			check(8'(output_on_control), 8'h00);
			rd(2, {24'h000000, f});
			{uv_detect, temp_detect} = 2'b00;
			wt(20);
			rd(3, {16'h0001, 8'h00, f});
			check(8'(irq_n_oe), 8'h00);
			wr(en);
			check(8'(output_on_control), 8'h01);
		end
		{ocp_timer_on, ocp_detect} = 2'b11;
		wt(60);
		check(8'(output_on_control), 8'h00);
		rd(3, 32'h00010005);
		ocp_detect = 1'b0;
		wr(en);
		ocp_timer_on = 1'b0;
		ocp_detect = 1'b1;
		wt(20);
		check(8'(output_on_control), 8'h01);
		rd(1, 32'h04);
		temp_detect = 1'b1;
		wt(20);
		rd(1, 32'h45);
		{ocp_detect, temp_detect} = 2'b00;
		wt(20);
		rd(2, 32'h0041);
		wr(en);
		check(8'(output_on_control), 8'h01);
		wr(8'h00);
		check(8'(output_on_control), 8'h00);
		check(8'(irq_n_oe), 8'h00);
		rd(1, 32'h01);
		check(8'(exp_q.size()), 8'h00);
		conclude();
	end
endmodule
`default_nettype wire
